// *** design/fcpc_top.sv ***
// flash cache and prefetch control: registers, wait states, invalidation
// assumes flash access starts and programming events are on the system clock
//
// Summary of operation
// [R1] data coherency bit set: programming event invalidates data cache; clear: never
// [R2] instruction coherency bit set: programming event invalidates instruction cache
// [R3] performance counters count only while the counter enable bit is set
// [R4] extra address wait bit adds one wait state to the programmed field
// [R5] software sets extra address wait at high clock rates only
// [R6] prefetch field enables instruction prefetch only for value 01
// [R7] three-bit wait field gives zero to seven wait states directly
// [R8] software programs one, two, three waits up to 60, 80, 120 MHz
// [R9] low-power read select picks five-bit low-power wait field instead
// [R10] hardware clears each invalidate request bit when its invalidation ends
// [R11] software keeps coherency bits stable before programming starts
// [R12] unimplemented control bits read zero and ignore writes
// [R13] new wait or prefetch settings apply from the next access start
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fcpc_top
  import fcpc_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic prog_event_i,
  input wire logic access_start_i,
  input wire logic cache_hit_i,
  output fcpc_access_cfg_t access_cfg_o,
  output logic dcache_inv_o,
  output logic icache_inv_o,
  output logic periph_coh_o,
  output logic perf_en_o
);
  initial begin
    if (CNT_W < 1 || CNT_W > 32) $error("fcpc_top: CNT_W out of range");
  end

  // package constants must fit the fields and counters they feed
  initial begin
    if (FCPC_INV_CYCLES < 1 || FCPC_INV_CYCLES > 255) begin
      $error("fcpc_top: instruction invalidate length out of range");
    end
    if (FCPC_DCACHE_INV_CYCLES < 1 || FCPC_DCACHE_INV_CYCLES > 255) begin
      $error("fcpc_top: data invalidate length out of range");
    end
    if (FCPC_ADDR_CTRL == FCPC_ADDR_FLASH_CTRL || FCPC_ADDR_CTRL == FCPC_ADDR_FLASH_CTRL_TWO ||
        FCPC_ADDR_CTRL == FCPC_ADDR_PERF_HIT || FCPC_ADDR_FLASH_CTRL == FCPC_ADDR_PERF_HIT ||
        FCPC_ADDR_FLASH_CTRL == FCPC_ADDR_FLASH_CTRL_TWO ||
        FCPC_ADDR_FLASH_CTRL_TWO == FCPC_ADDR_PERF_HIT) begin
      $error("fcpc_top: register offsets collide");
    end
    if (FCPC_POS_WAITS + 3 > FCPC_POS_PREFETCH) begin
      $error("fcpc_top: wait field overlaps prefetch field");
    end
    if (FCPC_POS_PREFETCH + 2 > FCPC_BIT_ADDR_WAIT) begin
      $error("fcpc_top: prefetch field overlaps address wait bit");
    end
    if (FCPC_POS_LP_WAITS + 5 > 32) begin
      $error("fcpc_top: low-power wait field outside register");
    end
    if (FCPC_BIT_INV_DATA > 1 || FCPC_BIT_INV_INSTR > 1 ||
        FCPC_BIT_INV_DATA == FCPC_BIT_INV_INSTR) begin
      $error("fcpc_top: invalidate request bits misplaced");
    end
    if ((FCPC_CTRL_RESET & ~FCPC_CTRL_WMASK) != 32'h0000_0000) begin
      $error("fcpc_top: control reset sets unimplemented bits");
    end
  end

  // control registers
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] fctrl_r;
  logic [31:0] fctrl_nxt;
  logic [31:0] fctrl2_r;
  logic [31:0] fctrl2_nxt;
  logic [CNT_W-1:0] hits_r;
  logic [CNT_W-1:0] hits_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  fcpc_access_cfg_t cfg_r;
  fcpc_access_cfg_t cfg_nxt;
  fcpc_access_cfg_t cfg_live;

  logic data_coh;
  logic instr_coh;
  logic perf_en;
  logic [2:0] waits_main;
  logic [4:0] waits_lp;
  logic lp_sel;
  logic d_start;
  logic i_start;
  logic d_pend;
  logic i_pend;
  logic d_done;
  logic i_done;
  logic periph_coh;
  logic addr_wait;
  logic [1:0] prefetch_field;
  logic prefetch_on;
  logic [4:0] waits_main_total;
  logic [1:0] inv_req;
  logic wr_ctrl;
  logic wr_fctrl;
  logic wr_fctrl2;
  logic wr_hits;
  logic [31:0] ctrl_image;
  logic [31:0] fctrl_image;
  logic [31:0] fctrl2_image;
  logic [31:0] hits_image;

  assign data_coh = ctrl_r[FCPC_BIT_DATA_COH];
  assign instr_coh = ctrl_r[FCPC_BIT_INSTR_COH];
  assign perf_en = ctrl_r[FCPC_BIT_PERF_EN];
  assign waits_main = ctrl_r[FCPC_POS_WAITS +: 3];
  assign lp_sel = fctrl_r[FCPC_BIT_LP_SEL];
  assign waits_lp = fctrl2_r[FCPC_POS_LP_WAITS +: 5];
  assign periph_coh = ctrl_r[FCPC_BIT_PERIPH_COH];
  assign addr_wait = ctrl_r[FCPC_BIT_ADDR_WAIT];
  assign prefetch_field = ctrl_r[FCPC_POS_PREFETCH +: 2];

  // register port decode, one write strobe per register
  assign wr_ctrl = wr_i && (addr_i == FCPC_ADDR_CTRL);
  assign wr_fctrl = wr_i && (addr_i == FCPC_ADDR_FLASH_CTRL);
  assign wr_fctrl2 = wr_i && (addr_i == FCPC_ADDR_FLASH_CTRL_TWO);
  assign wr_hits = wr_i && (addr_i == FCPC_ADDR_PERF_HIT);

  // invalidation requests from programming events
  assign d_start = prog_event_i && data_coh; // R1
  assign i_start = prog_event_i && instr_coh; // R2

  fcpc_inv_seq #(
    .CYCLES(FCPC_DCACHE_INV_CYCLES)
  ) u_dinv (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(d_start),
    .pending_o(d_pend),
    .done_o(d_done)
  );

  fcpc_inv_seq #(
    .CYCLES(FCPC_INV_CYCLES)
  ) u_iinv (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(i_start),
    .pending_o(i_pend),
    .done_o(i_done)
  );

  // prefetch decode: only one code turns prefetch on
  always_comb begin
    case (prefetch_field)
      FCPC_PREFETCH_ON: begin
        prefetch_on = 1'b1; // R6
      end
      default: begin
        prefetch_on = 1'b0; // R6
      end
    endcase
  end

  // main path waits: field value plus the optional setup wait
  always_comb begin
    waits_main_total = {2'b00, waits_main}; // R7
    if (addr_wait) begin
      waits_main_total = {2'b00, waits_main} + 5'h01; // R4
    end
  end

  // live access configuration
  always_comb begin
    cfg_live.prefetch_en = prefetch_on; // R6
    if (lp_sel) begin
      cfg_live.waits = waits_lp; // R9
    end else begin
      cfg_live.waits = waits_main_total; // R9
    end
  end

  // invalidate request bits: set by hardware, cleared when done, set wins
  always_comb begin
    inv_req = 2'b00;
    inv_req[FCPC_BIT_INV_DATA] = d_start || (d_pend && !d_done); // R10
    inv_req[FCPC_BIT_INV_INSTR] = i_start || (i_pend && !i_done); // R10
  end

  // control register writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = wdata_i & FCPC_CTRL_WMASK; // R12
    end
  end

  // flash control: low-power select writable, request bits hardware owned
  always_comb begin
    fctrl_nxt = fctrl_r;
    if (wr_fctrl) begin
      fctrl_nxt = 32'h0000_0000; // R12
      fctrl_nxt[FCPC_BIT_LP_SEL] = wdata_i[FCPC_BIT_LP_SEL];
    end
    fctrl_nxt[FCPC_BIT_INV_DATA] = inv_req[FCPC_BIT_INV_DATA]; // R10
    fctrl_nxt[FCPC_BIT_INV_INSTR] = inv_req[FCPC_BIT_INV_INSTR]; // R10
  end

  // flash control two: only the low-power wait field is kept
  always_comb begin
    fctrl2_nxt = fctrl2_r;
    if (wr_fctrl2) begin
      fctrl2_nxt = 32'h0000_0000; // R12
      fctrl2_nxt[FCPC_POS_LP_WAITS +: 5] = wdata_i[FCPC_POS_LP_WAITS +: 5];
    end
  end

  // performance counter and access configuration latch
  always_comb begin
    hits_nxt = hits_r;
    if (perf_en && cache_hit_i) begin
      hits_nxt = hits_r + {{(CNT_W-1){1'b0}}, 1'b1}; // R3
    end
    if (wr_hits) begin
      hits_nxt = '0;
    end
    cfg_nxt = cfg_r;
    if (access_start_i) begin
      cfg_nxt = cfg_live; // R13
    end
  end

  // readback images: only implemented fields reach the port
  always_comb begin
    ctrl_image = 32'h0000_0000;
    ctrl_image[FCPC_BIT_PERIPH_COH] = periph_coh; // R12
    ctrl_image[FCPC_BIT_DATA_COH] = data_coh;
    ctrl_image[FCPC_BIT_INSTR_COH] = instr_coh;
    ctrl_image[FCPC_BIT_PERF_EN] = perf_en;
    ctrl_image[FCPC_BIT_ADDR_WAIT] = addr_wait;
    ctrl_image[FCPC_POS_PREFETCH +: 2] = prefetch_field;
    ctrl_image[FCPC_POS_WAITS +: 3] = waits_main;
  end

  always_comb begin
    fctrl_image = 32'h0000_0000;
    fctrl_image[FCPC_BIT_LP_SEL] = lp_sel; // R12
    fctrl_image[FCPC_BIT_INV_DATA] = fctrl_r[FCPC_BIT_INV_DATA]; // R10
    fctrl_image[FCPC_BIT_INV_INSTR] = fctrl_r[FCPC_BIT_INV_INSTR]; // R10
  end

  always_comb begin
    fctrl2_image = 32'h0000_0000;
    fctrl2_image[FCPC_POS_LP_WAITS +: 5] = waits_lp; // R12
  end

  always_comb begin
    hits_image = 32'h0000_0000;
    hits_image[CNT_W-1:0] = hits_r; // R3
  end

  // read data, one cycle later
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        FCPC_ADDR_CTRL: rdata_nxt = ctrl_image;
        FCPC_ADDR_FLASH_CTRL: rdata_nxt = fctrl_image;
        FCPC_ADDR_FLASH_CTRL_TWO: rdata_nxt = fctrl2_image;
        FCPC_ADDR_PERF_HIT: rdata_nxt = hits_image;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= FCPC_CTRL_RESET;
      fctrl_r <= FCPC_FCTRL_RESET;
      fctrl2_r <= FCPC_FCTRL2_RESET;
      hits_r <= '0;
      rdata_r <= 32'h0000_0000;
      cfg_r <= '{waits: FCPC_RESET_WAITS, prefetch_en: 1'b0};
    end else begin
      ctrl_r <= ctrl_nxt;
      fctrl_r <= fctrl_nxt;
      fctrl2_r <= fctrl2_nxt;
      hits_r <= hits_nxt;
      rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign access_cfg_o = cfg_r;
  assign dcache_inv_o = d_pend;
  assign icache_inv_o = i_pend;
  assign periph_coh_o = periph_coh;
  assign perf_en_o = perf_en;
endmodule : fcpc_top
`default_nettype wire

// *** common/fcpc_pkg.sv ***
// package for the flash cache and prefetch control block
// assumes a 32-bit register port and a 125 MHz system clock
package fcpc_pkg;
  localparam logic [3:0] FCPC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] FCPC_ADDR_FLASH_CTRL = 4'h4;
  localparam logic [3:0] FCPC_ADDR_FLASH_CTRL_TWO = 4'h8;
  localparam logic [3:0] FCPC_ADDR_PERF_HIT = 4'hC;
  localparam int FCPC_BIT_PERIPH_COH = 18;
  localparam int FCPC_BIT_DATA_COH = 17;
  localparam int FCPC_BIT_INSTR_COH = 16;
  localparam int FCPC_BIT_PERF_EN = 12;
  localparam int FCPC_BIT_ADDR_WAIT = 8;
  localparam int FCPC_POS_PREFETCH = 4;
  localparam int FCPC_POS_WAITS = 0;
  localparam int FCPC_BIT_LP_SEL = 15;
  localparam int FCPC_POS_LP_WAITS = 16;
  localparam int FCPC_BIT_INV_DATA = 1;
  localparam int FCPC_BIT_INV_INSTR = 0;
  localparam logic [31:0] FCPC_CTRL_WMASK = 32'h0007_1137;
  localparam logic [31:0] FCPC_CTRL_RESET = 32'h0000_0007;
  localparam logic [31:0] FCPC_FCTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FCPC_FCTRL2_RESET = 32'h0000_0000;
  localparam logic [4:0] FCPC_RESET_WAITS = 5'h07;
  localparam logic [1:0] FCPC_PREFETCH_ON = 2'h1;
  localparam int FCPC_INV_CYCLES = 4;
  localparam int FCPC_DCACHE_INV_CYCLES = 6;

  typedef struct packed {
    logic [4:0] waits;
    logic prefetch_en;
  } fcpc_access_cfg_t;
endpackage : fcpc_pkg

// *** design/fcpc_inv_seq.sv ***
// one cache invalidation sequencer: request bit set, busy count, self clear
// assumes start pulses come from the system clock domain
`timescale 1ns/1ps
`default_nettype none
module fcpc_inv_seq #(
  parameter int CYCLES = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic pending_o,
  output logic done_o
);
  initial begin
    if (CYCLES < 1 || CYCLES > 255) $error("fcpc_inv_seq: CYCLES out of range");
  end
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic pend_r;
  logic pend_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    done_o = 1'b0;
    if (pend_r) begin
      if (cnt_r == 8'h00) begin
        done_o = 1'b1;
        pend_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
    if (start_i) begin
      pend_nxt = 1'b1;
      cnt_nxt = 8'(CYCLES - 1);
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
      pend_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
    end
  end
  assign pending_o = pend_r;
endmodule : fcpc_inv_seq
`default_nettype wire

// *** verif/fcpc_top_properties.sv ***
// port checker for the flash cache and prefetch control top
// assumes a bind from the bench and one clock domain
`timescale 1ns/1ps
`default_nettype none
module fcpc_top_properties
  import fcpc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic prog_event_i,
  input wire logic access_start_i,
  input wire fcpc_access_cfg_t access_cfg_o,
  input wire logic dcache_inv_o,
  input wire logic icache_inv_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_dinv_cause: assert property (
    $rose(dcache_inv_o) |-> $past(prog_event_i)) else $error("data inval without event");
  a_iinv_cause: assert property (
    $rose(icache_inv_o) |-> $past(prog_event_i)) else $error("instr inval without event");
  a_iinv_length: assert property (
    $rose(icache_inv_o) |-> icache_inv_o[*4] ##1 !icache_inv_o) else $error("instr inval len");
  a_dinv_length: assert property (
    $rose(dcache_inv_o) |-> dcache_inv_o[*6] ##1 !dcache_inv_o) else $error("data inval len");
  a_cfg_hold: assert property (
    !$past(access_start_i) |-> $stable(access_cfg_o)) else $error("cfg changed mid access");
  a_rdata_idle: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0) else $error("read data outside slot");
  a_ctrl_unimpl: assert property (
    $past(rd_i) && $past(addr_i) == FCPC_ADDR_CTRL |-> (rdata_o & ~FCPC_CTRL_WMASK) == 32'h0)
    else $error("unimplemented bit set");
  a_unmapped_zero: assert property (
    $past(rd_i) && ($past(addr_i) & 4'h3) != 4'h0 |-> rdata_o == 32'h0)
    else $error("unmapped read nonzero");
endmodule : fcpc_top_properties
`default_nettype wire

// *** verif/fcpc_flash_model.sv ***
// flash array side: programming events, access starts, cache hits
// assumes the bench calls pulse between clock edges
`timescale 1ns/1ps
`default_nettype none
module fcpc_flash_model (
  input wire logic clock_i,
  output logic prog_event_o,
  output logic access_start_o,
  output logic cache_hit_o
);
  initial {prog_event_o, access_start_o, cache_hit_o} = 3'h0;
  // one-cycle event: 0 program, 1 access start, 2 cache hit
  task automatic pulse(input int k);
    @(posedge clock_i);
    prog_event_o <= (k == 0);
    access_start_o <= (k == 1);
    cache_hit_o <= (k == 2);
    @(posedge clock_i);
    {prog_event_o, access_start_o, cache_hit_o} <= 3'h0;
  endtask : pulse
endmodule : fcpc_flash_model
`default_nettype wire

// *** verif/fcpc_top_tb.sv ***
// self-checking bench for the flash cache and prefetch control top
// assumes the flash model and the port checker beside it
`timescale 1ns/1ps
`default_nettype none
module fcpc_top_tb;
  import fcpc_pkg::*;
  logic clock_i;
  logic rst_n_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic prog, acc, hit, dinv, iinv, pcoh, pen;
  fcpc_access_cfg_t cfg;
  int failures = 0;
  int total_checks = 0;
  int ci, cd;
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  fcpc_flash_model u_fm (.clock_i(clock_i), .prog_event_o(prog), .access_start_o(acc),
    .cache_hit_o(hit));
  fcpc_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .prog_event_i(prog), .access_start_i(acc),
    .cache_hit_i(hit), .access_cfg_o(cfg), .dcache_inv_o(dinv), .icache_inv_o(iinv),
    .periph_coh_o(pcoh), .perf_en_o(pen));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk("rdata", rdata_o, e);
  endtask : rd
  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    #400000 failures++;
    test_done();
  end
  initial begin
    rst_n_i <= 1'b0;
    addr_i <= 4'h0;
    wdata_i <= 32'h0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk("cfg_reset", {26'h0, cfg}, {26'h0, FCPC_RESET_WAITS, 1'b0});
    rd(FCPC_ADDR_CTRL, FCPC_CTRL_RESET);
    wr(FCPC_ADDR_CTRL, 32'hFFFF_FFFF);
    rd(FCPC_ADDR_CTRL, FCPC_CTRL_WMASK);
    chk("coh_perf", {30'h0, pcoh, pen}, 32'h3);
    rd(4'h1, 32'h0);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      wr(FCPC_ADDR_CTRL, {23'h0, i[3], 2'h0, i[1:0], 1'h0, i[2:0]});
      u_fm.pulse(1);
      #1 chk("cfg", {26'h0, cfg}, {26'h0, 5'(i[2:0]) + 5'(i[3]), i[1:0] == 2'h1});
    end
    wr(FCPC_ADDR_CTRL, 32'h0000_0103);
    #1 chk("cfg_hold", {26'h0, cfg}, {26'h0, 5'h8, 1'b0});
    wr(FCPC_ADDR_FLASH_CTRL, 32'h8000);
    wr(FCPC_ADDR_FLASH_CTRL_TWO, 32'h0015_0000);
    u_fm.pulse(1);
    #1 chk("cfg_lp", {26'h0, cfg}, {26'h0, 5'h15, 1'b0});
    wr(FCPC_ADDR_FLASH_CTRL, 32'h0);
    u_fm.pulse(1);
    #1 chk("cfg_main", {26'h0, cfg}, {26'h0, 5'h4, 1'b0});
    $display("wait state test done");
    for (int c = 0; c < 4; c++) begin
      wr(FCPC_ADDR_CTRL, {14'h0, c[1:0], 16'h3});
      u_fm.pulse(0);
      ci = 0;
      cd = 0;
      for (int n = 0; n < 12; n++) begin
        #1 ci += int'(iinv);
        cd += int'(dinv);
        @(posedge clock_i);
      end
      chk("icache_inv", ci, c[0] ? 4 : 0);
      chk("dcache_inv", cd, c[1] ? 6 : 0);
    end
    u_fm.pulse(0);
    rd(FCPC_ADDR_FLASH_CTRL, 32'h3);
    repeat (8) @(posedge clock_i);
    rd(FCPC_ADDR_FLASH_CTRL, 32'h0);
    $display("invalidate test done");
    wr(FCPC_ADDR_PERF_HIT, 32'h0);
    repeat (3) u_fm.pulse(2);
    rd(FCPC_ADDR_PERF_HIT, 32'h0);
    wr(FCPC_ADDR_CTRL, 32'h1003);
    repeat (3) u_fm.pulse(2);
    rd(FCPC_ADDR_PERF_HIT, 32'h3);
    $display("perf counter test done");
    test_done();
  end
endmodule : fcpc_top_tb
bind fcpc_top fcpc_top_properties u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .prog_event_i(prog_event_i),
  .access_start_i(access_start_i), .access_cfg_o(access_cfg_o),
  .dcache_inv_o(dcache_inv_o), .icache_inv_o(icache_inv_o));
`default_nettype wire
